/* design/mah_pkg.sv */
// Purpose: shared constants for the station address, hash and PHY blocks
// Assumes: 32-bit register port, byte offsets as printed
// Notes: all offsets, fields and timing counts live here, plus the address, hash, PHY field and value resets
`default_nettype none
package mah_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_ADDR_UPPER = 12'h104;
  localparam logic [11:0] OFS_ADDR_LOWER = 12'h108;
  localparam logic [11:0] OFS_HASH_UPPER = 12'h10C;
  localparam logic [11:0] OFS_HASH_LOWER = 12'h110;
  localparam logic [11:0] OFS_MGMT_CMD = 12'h114;
  localparam logic [11:0] OFS_MGMT_VALUE = 12'h118;
  localparam logic [11:0] OFS_FILTER_CTRL = 12'h180;
  // Reset values
  localparam logic [15:0] RST_ADDR_UPPER = 16'hFFFF;
  localparam logic [31:0] RST_ADDR_LOWER = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_HASH = 32'h0000_0000;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [4:0] RST_FIELD5 = 5'h00;
  // Command register fields
  localparam int CMD_PHYAD_HI = 15;
  localparam int CMD_PHYAD_LO = 11;
  localparam int CMD_REG_HI = 10;
  localparam int CMD_REG_LO = 6;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_PENDING_BIT = 0;
  // Management frame layout and pacing
  localparam int MDC_FREQ_HZ = 2_500_000;
  localparam int SYS_FREQ_HZ = 10_000_000;
  localparam int MDC_HALF = (SYS_FREQ_HZ / MDC_FREQ_HZ) / 2;
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] TA_BIT_POS = 6'h0E;
  localparam logic [1:0] ST_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  // Hash index from CRC bits
  localparam int HASH_MSB = 31;
  localparam int HASH_LSB = 26;
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [2:0] LAST_OCTET = 3'h5;
  typedef enum {MG_IDLE, MG_PRE, MG_FRAME, MG_DONE} mah_mgmt_e;
endpackage : mah_pkg
`default_nettype wire

/* design/mah_hash_filter.sv */
// Purpose: multicast group acceptance from a 64-bit hash table
// Assumes: destination address given octet by octet, first octet first
// Notes: result is registered once the sixth octet is in
`default_nettype none
module mah_hash_filter (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic octet_valid,
  input wire logic [7:0] octet,
  input wire logic [63:0] hash_table,
  input wire logic pass_every_multicast,
  output logic verdict_valid,
  output logic accept
);
  typedef struct packed {
    logic [31:0] crc;
    logic [2:0] count;
    logic verdict_valid;
    logic accept;
  } mah_hf_s;
  mah_hf_s st, next_st;

  // Ethernet CRC over one octet, LSB of the octet first
  function automatic logic [31:0] crc_octet(input logic [31:0] c,
                                             input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[31] ^ d[i]) begin
        r = {r[30:0], 1'b0} ^ mah_pkg::CRC_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Accumulate CRC and judge on the sixth octet
  always_comb begin
    logic [31:0] c;
    logic [5:0] idx;
    c = '0;
    idx = '0;
    next_st = st;
    next_st.verdict_valid = 1'b0;
    if (octet_valid) begin
      c = crc_octet(st.crc, octet);
      next_st.crc = c;
      next_st.count = st.count + 3'h1;
      if (st.count == mah_pkg::LAST_OCTET) begin
        idx = c[mah_pkg::HASH_MSB:mah_pkg::HASH_LSB];
        next_st.crc = mah_pkg::CRC_INIT;
        next_st.count = '0;
        next_st.verdict_valid = 1'b1;
        next_st.accept = pass_every_multicast | hash_table[idx];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '{crc: mah_pkg::CRC_INIT, count: 3'h0,
              verdict_valid: 1'b0, accept: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign verdict_valid = st.verdict_valid;
  assign accept = st.accept;
endmodule // mah_hash_filter
`default_nettype wire

/* design/mah_mgmt_frame.sv */
// Purpose: clause-22 management frame engine toward the internal PHY
// Assumes: the PHY samples data on the rising management clock edge
// Notes: read data captured on the rising management clock edge
`default_nettype none
module mah_mgmt_frame (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic write_op,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] phy_reg_select,
  input wire logic [15:0] wr_value,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  output logic done,
  output logic [15:0] rd_value
);
  typedef struct packed {
    mah_pkg::mah_mgmt_e state;
    logic [7:0] div;
    logic [5:0] bitn;
    logic [31:0] shreg;
    logic write_op;
    logic mdc;
    logic mdio_out;
    logic mdio_oe;
    logic done;
    logic [15:0] rd_value;
  } mah_mf_s;
  mah_mf_s st, next_st;

  // Divider ticks every half period; frame bits move on falling MDC
  always_comb begin
    logic half;
    logic fall;
    logic rise;
    half = (st.div == 8'(mah_pkg::MDC_HALF - 1));
    fall = half & st.mdc;
    rise = half & ~st.mdc;
    next_st = st;
    next_st.done = 1'b0;
    if (st.state == mah_pkg::MG_IDLE) begin
      next_st.div = '0;
      next_st.mdc = 1'b0;
    end else begin
      next_st.div = half ? 8'h00 : st.div + 8'h01;
      if (half) begin
        next_st.mdc = ~st.mdc;
      end
    end
    case (st.state)
      mah_pkg::MG_IDLE: begin
        if (start) begin
          next_st.shreg = {mah_pkg::ST_CODE,
                           write_op ? mah_pkg::OP_WRITE : mah_pkg::OP_READ,
                           phy_addr, phy_reg_select, mah_pkg::TA_WRITE,
                           wr_value};
          next_st.write_op = write_op;
          next_st.bitn = mah_pkg::PREAMBLE_BITS;
          next_st.mdio_oe = 1'b1;
          next_st.mdio_out = 1'b1;
          next_st.state = mah_pkg::MG_PRE;
        end
      end
      mah_pkg::MG_PRE: begin
        if (fall) begin
          next_st.bitn = st.bitn - 6'h01;
          if (st.bitn == 6'h01) begin
            next_st.bitn = mah_pkg::FRAME_BITS;
            next_st.state = mah_pkg::MG_FRAME;
            next_st.mdio_out = st.shreg[31];
            next_st.shreg = {st.shreg[30:0], 1'b0};
          end
        end
      end
      mah_pkg::MG_FRAME: begin
        if (rise && !st.write_op) begin
          next_st.rd_value = {st.rd_value[14:0], mdio_in};
        end
        if (fall) begin
          next_st.bitn = st.bitn - 6'h01;
          // Release the line for turnaround on reads
          if (!st.write_op && st.bitn ==
              mah_pkg::FRAME_BITS - mah_pkg::TA_BIT_POS + 6'h01) begin
            next_st.mdio_oe = 1'b0;
          end
          next_st.mdio_out = st.shreg[31];
          next_st.shreg = {st.shreg[30:0], 1'b0};
          if (st.bitn == 6'h01) begin
            next_st.mdio_oe = 1'b0;
            next_st.state = mah_pkg::MG_DONE;
          end
        end
      end
      mah_pkg::MG_DONE: begin
        next_st.done = 1'b1;
        next_st.state = mah_pkg::MG_IDLE;
      end
      default: next_st.state = mah_pkg::MG_IDLE;
    endcase
  end

  // Frame engine state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '{state: mah_pkg::MG_IDLE, div: 8'h00, bitn: 6'h00,
              shreg: 32'h0000_0000, write_op: 1'b0, mdc: 1'b0,
              mdio_out: 1'b1, mdio_oe: 1'b0, done: 1'b0,
              rd_value: 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  assign mdc = st.mdc;
  assign mdio_out = st.mdio_out;
  assign mdio_oe = st.mdio_oe;
  assign done = st.done;
  assign rd_value = st.rd_value;
endmodule // mah_mgmt_frame
`default_nettype wire

/* design/mah_regs.sv */
// Purpose: station address, multicast hash and PHY management registers
// Assumes: plain register port, read data one cycle after the strobe
// Notes: reset protection is modelled by a separate protect input
//
// Our own choice: the strobed register port.
`default_nettype none
module mah_regs (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rst_protect,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic rx_dest_valid,
  input wire logic [7:0] rx_dest_octet,
  output logic rx_verdict_valid,
  output logic rx_accept,
  output logic [47:0] station_addr,
  output logic mgmt_clk,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  input wire logic mgmt_data_in
);
  typedef struct packed {
    logic [15:0] addr_upper;
    logic prot_armed;
    logic [31:0] hash_upper;
    logic [31:0] hash_lower;
    logic [4:0] phy_addr;
    logic [4:0] phy_reg_select;
    logic phy_write_select;
    logic phy_access_pending;
    logic start;
    logic [15:0] value;
    logic pass_every_multicast;
    logic [31:0] rdata;
    logic [47:0] station;
  } mah_rg_s;
  mah_rg_s st, next_st;
  // Lower word sits outside the state so it can ride through a reset
  logic [31:0] addr_lower;
  logic [31:0] next_addr_lower;

  logic mf_done;
  logic [15:0] mf_rd_value;
  logic mf_mdc;
  logic mf_out;
  logic mf_oe;
  logic hf_valid;
  logic hf_accept;

  // Read mux shared by the read path
  function automatic logic [31:0] read_word(input mah_rg_s s,
                                            input logic [31:0] lw,
                                            input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      mah_pkg::OFS_ADDR_UPPER: w = {16'h0000, s.addr_upper};
      mah_pkg::OFS_ADDR_LOWER: w = lw;
      mah_pkg::OFS_HASH_UPPER: w = s.hash_upper;
      mah_pkg::OFS_HASH_LOWER: w = s.hash_lower;
      mah_pkg::OFS_MGMT_CMD: begin
        w[mah_pkg::CMD_PHYAD_HI:mah_pkg::CMD_PHYAD_LO] = s.phy_addr;
        w[mah_pkg::CMD_REG_HI:mah_pkg::CMD_REG_LO] = s.phy_reg_select;
        w[mah_pkg::CMD_WRITE_BIT] = s.phy_write_select;
        w[mah_pkg::CMD_PENDING_BIT] = s.phy_access_pending;
      end
      mah_pkg::OFS_MGMT_VALUE: w = {16'h0000, s.value};
      mah_pkg::OFS_FILTER_CTRL: w = {31'h0000_0000, s.pass_every_multicast};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Register writes, pending handling and read capture
  always_comb begin
    next_st = st;
    next_addr_lower = addr_lower;
    next_st.start = 1'b0;
    next_st.prot_armed = 1'b1;
    next_st.rdata = 32'h0000_0000;
    // first edge after reset reloads unless protected
    if (!st.prot_armed && !rst_protect) begin
      next_addr_lower = mah_pkg::RST_ADDR_LOWER;
    end
    if (reg_read) begin
      next_st.rdata = read_word(st, addr_lower, reg_addr);
    end
    if (reg_write) begin
      case (reg_addr)
        mah_pkg::OFS_ADDR_UPPER: next_st.addr_upper = reg_wdata[15:0];
        mah_pkg::OFS_ADDR_LOWER: next_addr_lower = reg_wdata;
        mah_pkg::OFS_HASH_UPPER: next_st.hash_upper = reg_wdata;
        mah_pkg::OFS_HASH_LOWER: next_st.hash_lower = reg_wdata;
        mah_pkg::OFS_MGMT_CMD: begin
          if (!st.phy_access_pending) begin
            next_st.phy_addr =
              reg_wdata[mah_pkg::CMD_PHYAD_HI:mah_pkg::CMD_PHYAD_LO];
            next_st.phy_reg_select =
              reg_wdata[mah_pkg::CMD_REG_HI:mah_pkg::CMD_REG_LO];
            next_st.phy_write_select = reg_wdata[mah_pkg::CMD_WRITE_BIT];
            next_st.phy_access_pending =
              reg_wdata[mah_pkg::CMD_PENDING_BIT];
            next_st.start = reg_wdata[mah_pkg::CMD_PENDING_BIT];
          end
        end
        mah_pkg::OFS_MGMT_VALUE: begin
          if (!st.phy_access_pending) begin
            next_st.value = reg_wdata[15:0];
          end
        end
        mah_pkg::OFS_FILTER_CTRL:
          next_st.pass_every_multicast = reg_wdata[0];
        default: ;
      endcase
    end
    if (mf_done) begin
      if (!st.phy_write_select) begin
        next_st.value = mf_rd_value;
      end
      next_st.phy_access_pending = 1'b0;
    end
    next_st.station = {next_st.addr_upper[15:8], next_st.addr_upper[7:0],
                       next_addr_lower[31:24], next_addr_lower[23:16],
                       next_addr_lower[15:8], next_addr_lower[7:0]};
  end

  // all-ones address after reset; protected lower word
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st.addr_upper <= mah_pkg::RST_ADDR_UPPER;
      st.prot_armed <= 1'b0;
      st.hash_upper <= mah_pkg::RST_HASH;
      st.hash_lower <= mah_pkg::RST_HASH;
      st.phy_addr <= mah_pkg::RST_FIELD5;
      st.phy_reg_select <= mah_pkg::RST_FIELD5;
      st.phy_write_select <= 1'b0;
      st.phy_access_pending <= 1'b0;
      st.start <= 1'b0;
      st.value <= mah_pkg::RST_VALUE;
      st.pass_every_multicast <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.station <= {mah_pkg::RST_ADDR_UPPER, mah_pkg::RST_ADDR_LOWER};
    end else begin
      st.addr_upper <= next_st.addr_upper;
      st.prot_armed <= next_st.prot_armed;
      st.hash_upper <= next_st.hash_upper;
      st.hash_lower <= next_st.hash_lower;
      st.phy_addr <= next_st.phy_addr;
      st.phy_reg_select <= next_st.phy_reg_select;
      st.phy_write_select <= next_st.phy_write_select;
      st.phy_access_pending <= next_st.phy_access_pending;
      st.start <= next_st.start;
      st.value <= next_st.value;
      st.pass_every_multicast <= next_st.pass_every_multicast;
      st.rdata <= next_st.rdata;
      st.station <= next_st.station;
    end
  end

  // no async reset here, or protection could not hold the word
  always_ff @(posedge clk_sys) begin
    addr_lower <= next_addr_lower;
  end

  mah_mgmt_frame u_frame (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(st.start),
    .write_op(st.phy_write_select),
    .phy_addr(st.phy_addr),
    .phy_reg_select(st.phy_reg_select),
    .wr_value(st.value),
    .mdio_in(mgmt_data_in),
    .mdc(mf_mdc),
    .mdio_out(mf_out),
    .mdio_oe(mf_oe),
    .done(mf_done),
    .rd_value(mf_rd_value)
  );

  mah_hash_filter u_filter (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .octet_valid(rx_dest_valid),
    .octet(rx_dest_octet),
    .hash_table({st.hash_upper, st.hash_lower}),
    .pass_every_multicast(st.pass_every_multicast),
    .verdict_valid(hf_valid),
    .accept(hf_accept)
  );

  assign reg_rdata = st.rdata;
  assign station_addr = st.station;
  assign rx_verdict_valid = hf_valid;
  assign rx_accept = hf_accept;
  assign mgmt_clk = mf_mdc;
  assign mgmt_data_out = mf_out;
  assign mgmt_data_oe = mf_oe;
endmodule // mah_regs
`default_nettype wire

/* bench/mah_regs_props.sv */
// Purpose: port-level checks on the register, filter and PHY paths
// Assumes: the bench leaves one idle cycle after each write strobe
// Notes: bound to mah_regs from the bench top file
`default_nettype none
module mah_regs_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rst_protect,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic rx_dest_valid,
  input wire logic rx_verdict_valid,
  input wire logic rx_accept,
  input wire logic [47:0] station_addr,
  input wire logic mgmt_clk,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Lower word as it stood before the latest reset
  logic nrst_q = 1'b0;
  logic [31:0] kept = 32'h0000_0000;
  always @(posedge clk_sys) begin
    nrst_q <= nrst;
    if (nrst && nrst_q) kept <= station_addr[31:0];
  end
  // Bus steps shared by the register checks
  sequence s_wr(logic [11:0] a);
    reg_write && reg_addr == a;
  endsequence
  sequence s_wr_rd(logic [11:0] a);
    s_wr(a) ##2 (reg_read && reg_addr == a);
  endsequence
  AST_ADDR_UPPER: assert property (
    s_wr(12'h104) |=> station_addr[47:32] == $past(reg_wdata[15:0]))
    else $error("upper address field not taken");
  AST_ADDR_LOWER: assert property (
    s_wr(12'h108) |=> station_addr[31:0] == $past(reg_wdata))
    else $error("lower address octets not taken");
  AST_ADDR_RESET: assert property (
    $rose(nrst) |-> station_addr[47:32] == 16'hFFFF)
    else $error("upper address not all ones after reset");
  AST_LOWER_LOAD: assert property (
    $rose(nrst) && !rst_protect |=> station_addr[31:0] == 32'hFFFF_FFFF)
    else $error("lower address not all ones after reset");
  AST_LOWER_KEEP: assert property (
    $rose(nrst) && rst_protect |=> station_addr[31:0] == kept)
    else $error("protected lower address changed");
  AST_HASH_RW: assert property (
    s_wr_rd(12'h10C) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("hash upper read back wrong");
  AST_PENDING_SET: assert property (
    (reg_write && reg_addr == 12'h114 && reg_wdata[0]) ##2
    (reg_read && reg_addr == 12'h114) |=> reg_rdata[0])
    else $error("pending bit not held after start");
  AST_MCLK_HIGH: assert property (
    $rose(mgmt_clk) |=> mgmt_clk ##1 !mgmt_clk)
    else $error("management clock high time wrong");
  AST_MDATA_HOLD: assert property (
    mgmt_clk && $past(mgmt_clk) && mgmt_data_oe |-> $stable(mgmt_data_out))
    else $error("management data moved while clock high");
  AST_VERDICT: assert property (
    !rx_dest_valid ##1 rx_dest_valid [*6] |=> rx_verdict_valid)
    else $error("no verdict after sixth octet");
  AST_ACCEPT_HOLD: assert property (
    !rx_verdict_valid |-> $stable(rx_accept))
    else $error("accept moved without a verdict");
endmodule // mah_regs_props
`default_nettype wire

/* bench/mah_phy_model.sv */
// Purpose: behavioural internal PHY on the management line
// Assumes: a frame opens with the first zero after a run of ones
// Notes: read data change on the falling clock, the line has a pull-up
`default_nettype none
module mah_phy_model (
  input wire logic mgmt_clk,
  input wire logic mdio_line,
  output logic phy_oe,
  output logic phy_drive,
  output logic [4:0] last_phyad,
  output logic [4:0] last_reg,
  output logic [15:0] last_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [32];
  logic [5:0] cnt = 6'h00;
  logic [15:0] sr = 16'h0000;
  logic [1:0] op = 2'h0;
  // Known register pattern so the bench can predict reads
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = {11'h52D, i[4:0]};
    phy_oe = 1'b0;
    phy_drive = 1'b1;
  end
  always @(posedge mgmt_clk) begin
    if (cnt == 6'h00) begin
      if (mdio_line === 1'b0) cnt <= 6'h01;
    end else begin
      cnt <= (cnt == 6'h1F) ? 6'h00 : cnt + 6'h01;
    end
    sr <= {sr[14:0], mdio_line};
    if (cnt == 6'h0E) begin
      op <= sr[11:10];
      last_phyad <= sr[9:5];
      last_reg <= sr[4:0];
    end
    if (cnt == 6'h1F && op == mah_pkg::OP_WRITE) begin
      mem[last_reg] <= {sr[14:0], mdio_line};
      last_wdata <= {sr[14:0], mdio_line};
    end
  end
  // read data over the last 16 bit times
  always @(negedge mgmt_clk) begin
    phy_oe <= (cnt >= 6'h10) && (op == mah_pkg::OP_READ);
    phy_drive <= (cnt >= 6'h10) ? mem[last_reg][4'(6'h1F - cnt)] : 1'b1;
  end
endmodule // mah_phy_model
`default_nettype wire

/* bench/tb_mac_addr_hash_phy_mgmt.sv */
// Purpose: self-checking bench for address, hash filter and PHY access
// Assumes: 10 MHz clock, fixed seed for repeatable random traffic
// Notes: writes leave one idle cycle so strobes never double up
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  n_fail++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_mac_addr_hash_phy_mgmt;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, nrst = 1'b0, rst_protect = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_write = 1'b0, reg_read = 1'b0, rx_dest_valid = 1'b0;
  logic [7:0] rx_dest_octet = 8'h00;
  logic rx_verdict_valid, rx_accept, mgmt_clk, mgmt_data_out, mgmt_data_oe;
  logic phy_oe, phy_drive;
  logic [47:0] station_addr;
  logic [4:0] last_phyad, last_reg;
  logic [15:0] last_wdata;
  logic [15:0] shadow [32];
  int n_fail = 0, compares = 0, seed = 15553;
  wire logic mdio_line;
  // Pull-up wins when neither side drives
  assign mdio_line = mgmt_data_oe ? mgmt_data_out : (phy_oe ? phy_drive : 1'b1);
  always #50 clk_sys = ~clk_sys;
  mah_regs dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .rst_protect(rst_protect),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_dest_valid(rx_dest_valid), .rx_dest_octet(rx_dest_octet),
    .rx_verdict_valid(rx_verdict_valid), .rx_accept(rx_accept),
    .station_addr(station_addr), .mgmt_clk(mgmt_clk),
    .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe),
    .mgmt_data_in(mdio_line)
  );
  mah_phy_model phy_u (
    .mgmt_clk(mgmt_clk), .mdio_line(mdio_line), .phy_oe(phy_oe),
    .phy_drive(phy_drive), .last_phyad(last_phyad), .last_reg(last_reg),
    .last_wdata(last_wdata)
  );
  task automatic conclude;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Data sampled mid-cycle, clear of the launching edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] d;
    rd(a, d);
    `CHK("reg_rdata", ex, d)
  endtask
  task automatic do_reset(input logic prot);
    rst_protect <= prot;
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic send(input logic [47:0] a);
    int n;
    for (int i = 0; i < 6; i++) begin
      rx_dest_valid <= 1'b1;
      rx_dest_octet <= a[8*i +: 8];
      @(posedge clk_sys);
    end
    rx_dest_valid <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(negedge clk_sys);
      if (rx_verdict_valid === 1'b1) break;
      @(posedge clk_sys);
    end
    if (n == 4) begin
      n_fail++;
      conclude();
    end
    @(posedge clk_sys);
  endtask
  // Reference hash: first octet first, each octet lsb first
  function automatic logic [5:0] hash_idx(input logic [47:0] a);
    logic [31:0] c;
    c = mah_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? mah_pkg::CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction
  initial begin
    logic [31:0] d;
    logic [63:0] tbl;
    logic [47:0] da;
    logic [15:0] v;
    logic [4:0] r;
    logic pass, wop;
    int n;
    for (int i = 0; i < 32; i++) shadow[i] = {11'h52D, i[4:0]};
    do_reset(1'b0);
    rchk(12'h104, 32'h0000_FFFF);
    rchk(12'h108, 32'hFFFF_FFFF);
    rchk(12'h10C, 32'h0000_0000);
    rchk(12'h110, 32'h0000_0000);
    rchk(12'h118, 32'h0000_0000);
    rchk(12'h1F0, 32'h0000_0000);
    // Octet order for 12-34-56-78-9A-BC, reserved upper bits dropped
    wr(12'h108, 32'h7856_3412);
    wr(12'h104, 32'hFFFF_BC9A);
    rchk(12'h104, 32'h0000_BC9A);
    `CHK("station_addr", 48'hBC9A_7856_3412, station_addr)
    do_reset(1'b1);
    rchk(12'h108, 32'h7856_3412);
    rchk(12'h104, 32'h0000_FFFF);
    do_reset(1'b0);
    rchk(12'h108, 32'hFFFF_FFFF);
    // Random tables plus empty, lone-bit, all-but-one and pass-all cases
    for (int it = 0; it < 16; it++) begin
      da = 48'({$random(seed), $random(seed)});
      da[0] = 1'b1;
      tbl = {$random(seed), $random(seed)};
      if (it == 0) tbl = 64'h0;
      if (it == 1) tbl = 64'h1 << hash_idx(da);
      if (it == 2) tbl = ~(64'h1 << hash_idx(da));
      pass = (it % 4 == 3);
      wr(12'h10C, tbl[63:32]);
      rchk(12'h10C, tbl[63:32]);
      wr(12'h110, tbl[31:0]);
      wr(12'h180, {31'h0, pass});
      send(da);
      `CHK("rx_accept", pass | tbl[hash_idx(da)], rx_accept)
    end
    // Read one PHY register, then write another and read that one back
    for (int k = 0; k < 6; k++) begin
      if (k % 3 != 2) r = 5'($random(seed));
      wop = (k % 3 == 1);
      v = 16'($random(seed));
      if (wop) wr(12'h118, {16'h0, v});
      wr(12'h114, {16'h0, 5'h01, r, 4'h0, wop, 1'b1});
      // poll until idle, value left alone
      n = 0;
      d = 32'h1;
      while (d[0] !== 1'b0 && n < 400) begin
        rd(12'h114, d);
        n++;
      end
      if (n == 400) begin
        n_fail++;
        conclude();
      end
      if (wop) shadow[r] = v;
      `CHK("phy_addr", 5'h01, last_phyad)
      `CHK("phy_reg", r, last_reg)
      if (wop) `CHK("phy_wdata", v, last_wdata)
      rchk(12'h118, {16'h0, shadow[r]});
    end
    conclude();
  end
endmodule // tb_mac_addr_hash_phy_mgmt
bind mah_regs mah_regs_props chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .rst_protect(rst_protect),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rx_dest_valid(rx_dest_valid), .rx_verdict_valid(rx_verdict_valid),
  .rx_accept(rx_accept), .station_addr(station_addr),
  .mgmt_clk(mgmt_clk), .mgmt_data_out(mgmt_data_out),
  .mgmt_data_oe(mgmt_data_oe)
);
`default_nettype wire
